// ===== inc/ifec_cfg.svh
`ifndef IFEC_CFG_SVH
`define IFEC_CFG_SVH

// register offsets
`define IFEC_OFF_EDGE  8'h00
`define IFEC_OFF_CTRL0 8'h01
`define IFEC_OFF_CTRL1 8'h02
`define IFEC_OFF_CTRL2 8'h03
`define IFEC_OFF_MF0   8'h04
`define IFEC_OFF_MF1   8'h05

// edge select field positions (lsb of each field)
`define IFEC_EDGE0_LSB 0
`define IFEC_EDGE1_LSB 2

// primary control 0 bits
`define IFEC_C0_GIE    0
`define IFEC_C0_EXT0E  1
`define IFEC_C0_MULTI0_IRQ_ENABLE   2
`define IFEC_C0_MULTI1_IRQ_ENABLE   3
`define IFEC_C0_EXT0F  4
`define IFEC_C0_MULTI0_IRQ_FLAG   5
`define IFEC_C0_MULTI1_IRQ_FLAG   6

// primary control 1 bits
`define IFEC_C1_ADE    0
`define IFEC_C1_DEE    1
`define IFEC_C1_TIMEBASE0_IRQ_ENABLE   2
`define IFEC_C1_TIMEBASE1_IRQ_ENABLE   3
`define IFEC_C1_ADF    4
`define IFEC_C1_DEF    5
`define IFEC_C1_TIMEBASE0_IRQ_FLAG   6
`define IFEC_C1_TIMEBASE1_IRQ_FLAG   7

// primary control 2 bits
`define IFEC_C2_EXT1E  0
`define IFEC_C2_EXT1F  4

// multi-function register bits
`define IFEC_MF_PE     0
`define IFEC_MF_AE     1
`define IFEC_MF_PF     4
`define IFEC_MF_AF     5

// reset values
`define IFEC_RST_EDGE  4'h0
`define IFEC_RST_SRC   8'h00
`define IFEC_RST_SUB   4'h0
`define IFEC_RST_GIE   1'b0

`endif

// ===== inc/ifec_pkg.sv
package ifec_pkg;

    // active edge encoding of a pin field, 00..11 in order
    typedef enum logic [1:0] {
        EDGE_OFF,
        EDGE_RISE,
        EDGE_FALL,
        EDGE_BOTH
    } ifec_edge_e;

    // vector sources, listed from highest to lowest priority
    typedef enum logic [2:0] {
        VEC_EXT0,
        VEC_EXT1,
        VEC_MULTI0,
        VEC_MULTI1,
        VEC_CONV,
        VEC_EEPROM,
        VEC_TB0,
        VEC_TB1
    } ifec_vec_e;

    // register data
    typedef logic [7:0] ifec_byte_t;

endpackage

// ===== verification/ifec_core_model.sv
// core side: takes vectors, holds stack state, returns
module ifec_core_model (
    input wire logic                clk_sys,
    input wire logic                reset,
    input wire logic                irq_req_q,
    input wire ifec_pkg::ifec_vec_e irq_vec_q,
    input wire logic [3:0]          dly,
    input wire logic                full_cmd,
    input wire logic                ret_cmd,
    output logic                    irq_ack,
    output logic                    reti_evt,
    output logic                    stack_full,
    output ifec_pkg::ifec_vec_e     taken_vec,
    output logic [7:0]              taken_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    import ifec_pkg::*;

    logic [3:0] wait_q; // cycles before taking

    // ack after dly cycles, never while the stack is full
    always_ff @(posedge clk_sys) begin
        irq_ack <= 1'b0;
        reti_evt <= ret_cmd & ~reset; // end of service routine
        stack_full <= full_cmd & ~reset;
        if (reset) begin
            wait_q <= 4'h0;
            taken_cnt <= 8'h00;
        end else if (irq_req_q && !irq_ack && !stack_full) begin
            if (wait_q == dly) begin
                irq_ack <= 1'b1; // main program suspended
                taken_vec <= irq_vec_q;
                taken_cnt <= taken_cnt + 8'h01;
                wait_q <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

// ===== verification/ifec_top_properties.sv
`include "ifec_cfg.svh"

module ifec_top_properties #(
    parameter int EXT_PINS = 2
) (
    input wire logic                 clk_sys,
    input wire logic                 reset,
    input wire logic [7:0]           addr,
    input wire ifec_pkg::ifec_byte_t wr_data,
    input wire logic                 wr_en,
    input wire logic                 rd_en,
    input wire ifec_pkg::ifec_byte_t rd_data_q,
    input wire logic [1:0]           ext_irq_pin,
    input wire logic                 std_timer_cmpp_evt,
    input wire logic                 std_timer_cmpa_evt,
    input wire logic                 period_timer_cmpp_evt,
    input wire logic                 period_timer_cmpa_evt,
    input wire logic                 conv_done_evt,
    input wire logic                 eeprom_evt,
    input wire logic                 timebase0_evt,
    input wire logic                 timebase1_evt,
    input wire logic                 stack_full,
    input wire logic                 irq_ack,
    input wire logic                 reti_evt,
    input wire logic                 irq_req_q,
    input wire ifec_pkg::ifec_vec_e  irq_vec_q,
    input wire logic                 wake_q
);
    timeunit 1ns;
    timeprecision 1ps;
    import ifec_pkg::*;

    logic any_evt; // any internal event pulse
    assign any_evt = std_timer_cmpp_evt | std_timer_cmpa_evt | period_timer_cmpp_evt
        | period_timer_cmpa_evt | conv_done_evt | eeprom_evt | timebase0_evt | timebase1_evt;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // read data only in the slot after a read
    AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data_q == 8'h00)
        else $error("read data outside its slot");
    AST_UNMAPPED: assert property (rd_en && addr > `IFEC_OFF_MF1 |=> rd_data_q == 8'h00)
        else $error("unmapped read not zero");
    AST_EDGE_PAD: assert property (rd_en && addr == `IFEC_OFF_EDGE |=> rd_data_q[7:4] == 4'h0)
        else $error("edge register pad bits set");
    AST_C0_PAD: assert property (rd_en && addr == `IFEC_OFF_CTRL0 |=> !rd_data_q[7])
        else $error("ctrl0 bit 7 set");
    AST_C2_PAD: assert property (rd_en && addr == `IFEC_OFF_CTRL2 |=>
        (rd_data_q & (EXT_PINS > 1 ? 8'hEE : 8'hFF)) == 8'h00)
        else $error("ctrl2 pad bits set");
    AST_MF_PAD: assert property (rd_en && addr inside {`IFEC_OFF_MF0, `IFEC_OFF_MF1} |=>
        (rd_data_q & 8'hCC) == 8'h00)
        else $error("multi register pad bits set");
    // service drops the request and blocks the next one
    AST_ACK_DROP: assert property (irq_req_q && irq_ack |=> !irq_req_q [*2])
        else $error("request not dropped after ack");
    AST_FULL: assert property ($past(stack_full) |-> !irq_req_q)
        else $error("request with full stack");
    AST_WAKE: assert property (any_evt |-> ##2 wake_q)
        else $error("no wake after event");
    AST_REQ_FLAG: assert property (irq_req_q |-> wake_q)
        else $error("request without pending flag");
endmodule

// ===== verification/testbench.sv
`include "ifec_cfg.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ifec_pkg::*;

    logic       clk_sys, reset, wr_en, rd_en, irq_ack, reti_evt, stack_full;
    logic       irq_req_q, wake_q, full_cmd, ret_cmd;
    logic [7:0] addr, evt, taken_cnt;
    logic [1:0] pin;
    logic [3:0] dly;
    ifec_byte_t wr_data, rd_data_q, d, rd_small, ds;
    ifec_vec_e  irq_vec_q, taken_vec;
    int         bad_count, checked, i, m, e, k, ra;
    ifec_byte_t msk [6] = '{8'h0F, 8'h7F, 8'hFF, 8'h11, 8'h33, 8'h33};

    ifec_top #(.EXT_PINS(2)) dut (.clk_sys(clk_sys), .reset(reset), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
        .ext_irq_pin(pin), .std_timer_cmpp_evt(evt[0]), .std_timer_cmpa_evt(evt[1]),
        .period_timer_cmpp_evt(evt[2]), .period_timer_cmpa_evt(evt[3]),
        .conv_done_evt(evt[4]), .eeprom_evt(evt[5]), .timebase0_evt(evt[6]),
        .timebase1_evt(evt[7]), .stack_full(stack_full), .irq_ack(irq_ack),
        .reti_evt(reti_evt), .irq_req_q(irq_req_q), .irq_vec_q(irq_vec_q), .wake_q(wake_q));

    // smaller variant beside it: no second pin, no ctrl2
    ifec_top #(.EXT_PINS(1)) dut_small (.clk_sys(clk_sys), .reset(reset), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_small),
        .ext_irq_pin(pin), .std_timer_cmpp_evt(evt[0]), .std_timer_cmpa_evt(evt[1]),
        .period_timer_cmpp_evt(evt[2]), .period_timer_cmpa_evt(evt[3]),
        .conv_done_evt(evt[4]), .eeprom_evt(evt[5]), .timebase0_evt(evt[6]),
        .timebase1_evt(evt[7]), .stack_full(stack_full), .irq_ack(irq_ack),
        .reti_evt(reti_evt), .irq_req_q(), .irq_vec_q(), .wake_q());

    ifec_core_model core (.clk_sys(clk_sys), .reset(reset), .irq_req_q(irq_req_q),
        .irq_vec_q(irq_vec_q), .dly(dly), .full_cmd(full_cmd), .ret_cmd(ret_cmd),
        .irq_ack(irq_ack), .reti_evt(reti_evt), .stack_full(stack_full),
        .taken_vec(taken_vec), .taken_cnt(taken_cnt));

    // free running clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic wr(input int a, input ifec_byte_t v);
        @(posedge clk_sys);
        addr <= a[7:0];
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input int a, output ifec_byte_t v);
        @(posedge clk_sys);
        addr <= a[7:0];
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 v = rd_data_q;
        ds = rd_small;
    endtask

    task automatic chk(input ifec_byte_t got, input ifec_byte_t exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #80000;
        bad_count++;
        end_sim();
    end

    initial begin
        {reset, addr, wr_data, wr_en, rd_en, pin, evt} = {1'b1, 28'h0};
        {dly, full_cmd, ret_cmd, bad_count, checked} = '0;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        // reset values, unmapped places
        for (i = 0; i < 8; i++) begin
            rd(i, d);
            chk(d, 8'h00);
        end
        // access masks with the stack held full
        full_cmd <= 1'b1;
        for (i = 0; i < 6; i++) begin
            wr(i, 8'hFF);
            rd(i, d);
            chk(d, msk[i]);
            chk(ds, i == 0 ? 8'h03 : i == 3 ? 8'h00 : msk[i]);
            wr(i, 8'h00);
        end
        full_cmd <= 1'b0;
        // every edge mode on both pins
        for (i = 0; i < 2; i++) begin
            ra = i ? `IFEC_OFF_CTRL2 : `IFEC_OFF_CTRL0;
            for (m = 0; m < 4; m++) begin
                wr(`IFEC_OFF_EDGE, 8'(m << (2 * i)));
                for (e = 0; e < 2; e++) begin
                    @(posedge clk_sys);
                    pin[i] <= ~e[0];
                    repeat (6) @(posedge clk_sys);
                    rd(ra, d);
                    chk(d, ((m >> e) & 1) ? 8'h10 : 8'h00);
                    wr(ra, 8'h00);
                end
            end
        end
        // internal events set flags with enables off
        for (i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            evt <= 8'h01 << i;
            @(posedge clk_sys);
            evt <= 8'h00;
            ra = i < 4 ? 4 + i / 2 : 2;
            rd(ra, d);
            chk(d, 8'h01 << (i < 4 ? 4 + i % 2 : i));
            rd(`IFEC_OFF_CTRL0, d);
            chk(d, 8'h00);
            chk({7'h00, irq_req_q}, 8'h00);
            chk({7'h00, wake_q}, 8'h01);
            wr(ra, 8'h00);
            @(posedge clk_sys);
            #1 chk({7'h00, wake_q}, 8'h00);
        end
        // all sources at once, serviced in priority order
        full_cmd <= 1'b1;
        dly <= 4'h2;
        for (i = 5; i > 0; i--) begin
            wr(i, i > 3 ? 8'h03 : i == 3 ? 8'h01 : 8'h0F);
        end
        wr(`IFEC_OFF_EDGE, 8'h05);
        @(posedge clk_sys);
        pin <= 2'b11;
        evt <= 8'hFF;
        @(posedge clk_sys);
        evt <= 8'h00;
        repeat (8) @(posedge clk_sys);
        rd(`IFEC_OFF_CTRL0, d);
        chk(d, 8'h7F);
        chk({7'h00, irq_req_q}, 8'h00);
        full_cmd <= 1'b0;
        for (i = 0; i < 8; i++) begin
            for (k = 0; k < 50 && taken_cnt != i + 1; k++) @(posedge clk_sys);
            chk(taken_cnt, 8'(i + 1));
            chk({5'h00, taken_vec}, 8'(i));
            ret_cmd <= 1'b1;
            @(posedge clk_sys);
            ret_cmd <= 1'b0;
        end
        rd(`IFEC_OFF_CTRL1, d);
        chk(d, 8'h0F);
        end_sim();
    end
endmodule

bind ifec_top ifec_top_properties #(.EXT_PINS(EXT_PINS)) u_chk (.clk_sys(clk_sys),
    .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data_q(rd_data_q), .ext_irq_pin(ext_irq_pin),
    .std_timer_cmpp_evt(std_timer_cmpp_evt), .std_timer_cmpa_evt(std_timer_cmpa_evt),
    .period_timer_cmpp_evt(period_timer_cmpp_evt),
    .period_timer_cmpa_evt(period_timer_cmpa_evt), .conv_done_evt(conv_done_evt),
    .eeprom_evt(eeprom_evt), .timebase0_evt(timebase0_evt), .timebase1_evt(timebase1_evt),
    .stack_full(stack_full), .irq_ack(irq_ack), .reti_evt(reti_evt),
    .irq_req_q(irq_req_q), .irq_vec_q(irq_vec_q), .wake_q(wake_q));

// ===== verilog/ifec_edge_det.sv
`include "ifec_cfg.svh"

// one external pin: synchroniser, edge detect, one-cycle event
module ifec_edge_det (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              pin,
    input  wire ifec_pkg::ifec_edge_e sel,
    output logic                   evt_q
);
    import ifec_pkg::*;

    logic sync1_q;   // first stage, read only by sync2_q
    logic sync2_q;   // settled pin level
    logic prev_q;    // level one cycle earlier
    wire  rise;      // low to high seen
    wire  fall;      // high to low seen
    wire  hit;       // edge matches selection

    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;
    // decode of the two-bit field [RL1]
    assign hit  = ((sel == EDGE_RISE) & rise) |
                  ((sel == EDGE_FALL) & fall) |
                  ((sel == EDGE_BOTH) & (rise | fall));

    // chain runs through reset, so a pin idling high gives no false edge
    always_ff @(posedge clk_sys) begin
        sync1_q <= pin;      // two flops before any edge logic [RL17]
        sync2_q <= sync1_q;
        prev_q  <= sync2_q;
        if (reset) begin
            evt_q <= 1'b0;   // no event while held in reset
        end else begin
            evt_q <= hit;    // one pulse per qualifying edge [RL7]
        end
    end
endmodule

// ===== verilog/ifec_top.sv
// Contract
// (RL1) edge field: off, rise, fall, both
// (RL2) unimplemented register bits read zero
// (RL3) own enable and flag per source
// (RL4) primary registers hold main enables, flags
// (RL5) multi-function registers hold timer compare bits
// (RL6) edge select register configures pin edges
// (RL7) selected pin edge raises external request
// (RL8) timers, time bases, eeprom, converter raise requests
// (RL9) flag means pending; enable gates source
// (RL10) accepted interrupt suspends main program
// (RL11) second pin only in larger variant
// (RL12) flag sets always; vector needs both enables
// (RL13) service clears global enable, flags still set
// (RL14) no acknowledge while return stack full
// (RL15) any set flag wakes device
// (RL16) fixed priority, ext0 first, tb1 last
// (RL17) pins synchronised before edge detection
//
// Added by the designer: the plain strobed port and the placing of the registers.
`include "ifec_cfg.svh"

module ifec_top #(
    parameter int EXT_PINS = 2   // 2 = larger variant, 1 = smaller
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // register port
    input  wire logic [7:0]        addr,
    input  wire ifec_pkg::ifec_byte_t wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output ifec_pkg::ifec_byte_t   rd_data_q,
    // external interrupt pins
    input  wire logic [1:0]        ext_irq_pin,
    // internal event pulses
    input  wire logic              std_timer_cmpp_evt,
    input  wire logic              std_timer_cmpa_evt,
    input  wire logic              period_timer_cmpp_evt,
    input  wire logic              period_timer_cmpa_evt,
    input  wire logic              conv_done_evt,
    input  wire logic              eeprom_evt,
    input  wire logic              timebase0_evt,
    input  wire logic              timebase1_evt,
    // cpu core side
    input  wire logic              stack_full,
    input  wire logic              irq_ack,
    input  wire logic              reti_evt,
    output logic                   irq_req_q,
    output ifec_pkg::ifec_vec_e    irq_vec_q,
    output logic                   wake_q
);
    import ifec_pkg::*;

    // second pin exists only in the larger variant [RL11]
    localparam bit HAS_EXT1 = (EXT_PINS > 1);

    // state
    logic [3:0]  edge_sel_q;   // both pin fields [RL6]
    logic [3:0]  edge_sel_d;
    logic        gie_q;        // global enable, no flag [RL3]
    logic        gie_d;
    logic [7:0]  src_en_q;     // per vector enable [RL3]
    logic [7:0]  src_en_d;
    logic [7:0]  src_flag_q;   // per vector flag [RL3]
    logic [7:0]  src_flag_d;
    logic [3:0]  sub_en_q;     // std p, std a, per p, per a [RL5]
    logic [3:0]  sub_en_d;
    logic [3:0]  sub_flag_q;   // same order
    logic [3:0]  sub_flag_d;
    ifec_vec_e   vec_d;        // winner of priority search
    logic        req_d;        // next request level
    ifec_byte_t  rd_data_d;    // next read data

    // address decode
    wire wr_edge = wr_en && (addr == `IFEC_OFF_EDGE);
    wire wr_c0   = wr_en && (addr == `IFEC_OFF_CTRL0);
    wire wr_c1   = wr_en && (addr == `IFEC_OFF_CTRL1);
    // register absent in the smaller variant [RL11]
    wire wr_c2   = wr_en && (addr == `IFEC_OFF_CTRL2) && HAS_EXT1;
    wire wr_mf0  = wr_en && (addr == `IFEC_OFF_MF0);
    wire wr_mf1  = wr_en && (addr == `IFEC_OFF_MF1);

    // pin edge events
    wire [1:0] pin_evt;        // one pulse per detected edge

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            if (gi < EXT_PINS) begin : g_on
                // synchroniser and edge detector per pin [RL17]
                ifec_edge_det u_edge (
                    .clk_sys (clk_sys),
                    .reset   (reset),
                    .pin     (ext_irq_pin[gi]),
                    .sel     (ifec_edge_e'(edge_sel_q[2*gi +: 2])),
                    .evt_q   (pin_evt[gi])
                );
            end else begin : g_off
                // no pin in this variant
                assign pin_evt[gi] = 1'b0;
            end
        end
    endgenerate

    // source events
    // sub flags latch regardless of their enables [RL12]
    wire [3:0] sub_evt = {period_timer_cmpa_evt, period_timer_cmpp_evt,
                          std_timer_cmpa_evt, std_timer_cmpp_evt};

    // multi-function request only from enabled sub sources [RL9]
    wire mf0_evt = |(sub_evt[1:0] & sub_en_q[1:0]);
    wire mf1_evt = |(sub_evt[3:2] & sub_en_q[3:2]);

    // timer, time base, eeprom, converter requests [RL8]
    wire [7:0] src_evt = {timebase1_evt, timebase0_evt, eeprom_evt,
                          conv_done_evt, mf1_evt, mf0_evt,
                          pin_evt[1], pin_evt[0]};

    // software write images
    // which src bits a write touches, indexed by vector
    wire [7:0] src_we = {{4{wr_c1}}, wr_c0, wr_c0, wr_c2, wr_c0};

    // enable values from the write data [RL4]
    wire [7:0] src_en_wd = {wr_data[`IFEC_C1_TIMEBASE1_IRQ_ENABLE],
                            wr_data[`IFEC_C1_TIMEBASE0_IRQ_ENABLE],
                            wr_data[`IFEC_C1_DEE],
                            wr_data[`IFEC_C1_ADE],
                            wr_data[`IFEC_C0_MULTI1_IRQ_ENABLE],
                            wr_data[`IFEC_C0_MULTI0_IRQ_ENABLE],
                            wr_data[`IFEC_C2_EXT1E],
                            wr_data[`IFEC_C0_EXT0E]};

    // flag values from the write data [RL4]
    wire [7:0] src_fl_wd = {wr_data[`IFEC_C1_TIMEBASE1_IRQ_FLAG],
                            wr_data[`IFEC_C1_TIMEBASE0_IRQ_FLAG],
                            wr_data[`IFEC_C1_DEF],
                            wr_data[`IFEC_C1_ADF],
                            wr_data[`IFEC_C0_MULTI1_IRQ_FLAG],
                            wr_data[`IFEC_C0_MULTI0_IRQ_FLAG],
                            wr_data[`IFEC_C2_EXT1F],
                            wr_data[`IFEC_C0_EXT0F]};

    // multi-function sub bits touched by a write [RL5]
    wire [3:0] sub_we = {wr_mf1, wr_mf1, wr_mf0, wr_mf0};
    wire [3:0] sub_en_wd = {2{wr_data[`IFEC_MF_AE], wr_data[`IFEC_MF_PE]}};
    wire [3:0] sub_fl_wd = {2{wr_data[`IFEC_MF_AF], wr_data[`IFEC_MF_PF]}};

    // enabled and pending sources [RL12]
    wire [7:0] pending = src_flag_q & src_en_q;

    // next state
    always_comb begin
        // edge fields, pin 1 field held zero when absent [RL11]
        edge_sel_d = edge_sel_q;
        if (wr_edge) begin
            edge_sel_d[`IFEC_EDGE0_LSB +: 2] = wr_data[`IFEC_EDGE0_LSB +: 2];
            if (HAS_EXT1) begin
                edge_sel_d[`IFEC_EDGE1_LSB +: 2] = wr_data[`IFEC_EDGE1_LSB +: 2];
            end
        end

        // global enable: write, return sets, service clears
        gie_d = gie_q;
        if (wr_c0) begin
            gie_d = wr_data[`IFEC_C0_GIE];
        end
        if (reti_evt) begin
            gie_d = 1'b1;
        end
        if (irq_ack && irq_req_q) begin
            gie_d = 1'b0;  // blocks nesting on service [RL13]
        end

        // vector enables and flags
        for (int i = 0; i < 8; i++) begin
            src_en_d[i]   = src_we[i] ? src_en_wd[i] : src_en_q[i];
            src_flag_d[i] = src_we[i] ? src_fl_wd[i] : src_flag_q[i];
            // serviced vector drops its flag
            if (irq_ack && irq_req_q && (irq_vec_q == ifec_vec_e'(i))) begin
                src_flag_d[i] = 1'b0;
            end
            // new event wins over any clear, enable ignored [RL12]
            src_flag_d[i] = src_flag_d[i] | src_evt[i];  // [RL13]
        end

        // multi-function sub enables and flags
        for (int j = 0; j < 4; j++) begin
            sub_en_d[j]   = sub_we[j] ? sub_en_wd[j] : sub_en_q[j];
            sub_flag_d[j] = sub_we[j] ? sub_fl_wd[j] : sub_flag_q[j];
            // set wins over software clear [RL12]
            sub_flag_d[j] = sub_flag_d[j] | sub_evt[j];
        end

        // fixed priority, lowest index first [RL16]
        vec_d = VEC_TB1;
        for (int k = 7; k >= 0; k--) begin
            if (pending[k]) begin
                vec_d = ifec_vec_e'(k);
            end
        end

        // request needs source, global enable and stack room
        req_d = gie_q && (|pending) && !stack_full  // [RL12] [RL14]
                && !(irq_ack && irq_req_q);
    end

    // read image
    // unimplemented bits tie to zero [RL2]
    wire [7:0] img_edge = {4'h0, edge_sel_q};
    wire [7:0] img_c0   = {1'b0,
                           src_flag_q[VEC_MULTI1],
                           src_flag_q[VEC_MULTI0],
                           src_flag_q[VEC_EXT0],
                           src_en_q[VEC_MULTI1],
                           src_en_q[VEC_MULTI0],
                           src_en_q[VEC_EXT0],
                           gie_q};
    wire [7:0] img_c1   = {src_flag_q[VEC_TB1],
                           src_flag_q[VEC_TB0],
                           src_flag_q[VEC_EEPROM],
                           src_flag_q[VEC_CONV],
                           src_en_q[VEC_TB1],
                           src_en_q[VEC_TB0],
                           src_en_q[VEC_EEPROM],
                           src_en_q[VEC_CONV]};
    // second pin register reads zero when absent [RL11]
    wire [7:0] img_c2   = HAS_EXT1 ? {3'h0, src_flag_q[VEC_EXT1], 3'h0,
                                      src_en_q[VEC_EXT1]} : 8'h00;
    wire [7:0] img_mf0  = {2'h0, sub_flag_q[1], sub_flag_q[0],
                           2'h0, sub_en_q[1], sub_en_q[0]};
    wire [7:0] img_mf1  = {2'h0, sub_flag_q[3], sub_flag_q[2],
                           2'h0, sub_en_q[3], sub_en_q[2]};

    // read select, unmapped reads zero
    wire [7:0] rd_sel =
        (addr == `IFEC_OFF_EDGE)  ? img_edge :
        (addr == `IFEC_OFF_CTRL0) ? img_c0   :
        (addr == `IFEC_OFF_CTRL1) ? img_c1   :
        (addr == `IFEC_OFF_CTRL2) ? img_c2   :
        (addr == `IFEC_OFF_MF0)   ? img_mf0  :
        (addr == `IFEC_OFF_MF1)   ? img_mf1  : 8'h00;  // [RL2]

    // data only in the cycle after the strobe
    assign rd_data_d = rd_en ? rd_sel : 8'h00;

    // registers
    // configuration and enable bits
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            edge_sel_q <= `IFEC_RST_EDGE;
            gie_q      <= `IFEC_RST_GIE;
            src_en_q   <= `IFEC_RST_SRC;
            sub_en_q   <= `IFEC_RST_SUB;
        end else begin
            edge_sel_q <= edge_sel_d;
            gie_q      <= gie_d;
            src_en_q   <= src_en_d;
            sub_en_q   <= sub_en_d;
        end
    end

    // request flags
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            src_flag_q <= `IFEC_RST_SRC;
            sub_flag_q <= `IFEC_RST_SUB;
        end else begin
            src_flag_q <= src_flag_d;  // [RL9]
            sub_flag_q <= sub_flag_d;
        end
    end

    // outputs toward the core
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_req_q <= 1'b0;
            irq_vec_q <= VEC_EXT0;
            wake_q    <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            irq_req_q <= req_d;      // core suspends on this [RL10]
            irq_vec_q <= vec_d;      // [RL16]
            wake_q    <= (|src_flag_q) | (|sub_flag_q);  // [RL15]
            rd_data_q <= rd_data_d;
        end
    end
endmodule
